// ==== hw/llc_defines.svh ====
`ifndef LLC_DEFINES_SVH
`define LLC_DEFINES_SVH
`define LLC_OFS_INSERT_LO     6'h11
`define LLC_OFS_STATUS_LO     6'h12
`define LLC_OFS_RX_INV_LO     6'h13
`define LLC_OFS_TX_INV_LO     6'h14
`define LLC_OFS_CLK_CFG       6'h15
`define LLC_OFS_GATE_LO       6'h16
`define LLC_OFS_IRQ_CFG       6'h1E
`define LLC_OFS_TESTER_HI     6'h30
`define LLC_OFS_INSERT_HI     6'h31
`define LLC_OFS_STATUS_HI     6'h32
`define LLC_OFS_RX_INV_HI     6'h33
`define LLC_OFS_TX_INV_HI     6'h34
`define LLC_OFS_GATE_HI       6'h36
`define LLC_RESET_BYTE        8'h00
`define LLC_IRQ_CFG_MASK      8'h03
`define LLC_TESTER_MASK       8'hE1
`define LLC_BIT_WOC           0
`define LLC_BIT_IDLE_DRIVE    1
`define LLC_BIT_TESTER_EN     0
`define LLC_BIT_RATE          4
`define LLC_BANK_LOW          2'h1
`define LLC_BANK_HIGH         2'h2
`define LLC_LV_WINDOW         2'h3
`define LLC_LOSS_SWITCH_MS    10
`endif

// ==== hw/llc_pkg.sv ====
package llc_pkg;
    typedef logic [7:0]  llc_byte_t;
    typedef logic [5:0]  llc_addr_t;
    typedef logic [15:0] llc_chan_t;
    typedef logic [15:0] llc_khz_t;
endpackage

// ==== hw/llc_line_clock_regs.sv ====
`timescale 1ns/1ps
`include "llc_defines.svh"
module llc_line_clock_regs (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             line_clk,
    input  wire llc_pkg::llc_addr_t host_addr,
    input  wire llc_pkg::llc_byte_t host_wdata,
    input  wire logic             host_wr,
    input  wire logic             host_rd,
    output llc_pkg::llc_byte_t    host_rdata,
    input  wire llc_pkg::llc_chan_t rx_bpv_event,
    input  wire llc_pkg::llc_chan_t rx_cv_event,
    input  wire llc_pkg::llc_chan_t rx_zero_run_event,
    input  wire llc_pkg::llc_chan_t zero_run_detect_enable,
    input  wire llc_pkg::llc_chan_t code_violation_detect_disable,
    input  wire logic             hdb3_mode,
    output llc_pkg::llc_chan_t    tx_violation_insert,
    output llc_pkg::llc_chan_t    tx_sample_falling,
    input  wire llc_pkg::llc_chan_t rx_recovered_clk,
    input  wire llc_pkg::llc_chan_t loss_of_signal,
    input  wire logic             master_clk,
    output llc_pkg::llc_chan_t    rx_clock_out,
    input  wire logic [1:0]       pll_ref_bank,
    output logic                  pll_ref_clk,
    output logic [3:0]            pll_ref_channel,
    output logic                  rate_clock_2048,
    output llc_pkg::llc_khz_t     aux_clock_khz,
    input  wire logic             irq_active,
    output logic                  irq_n_o,
    output logic                  irq_n_oe,
    output logic [7:0]            tester_channel_onehot
);
    import llc_pkg::*;

    // Aux clock frequency lookup in kHz
    function automatic llc_khz_t aux_khz(input logic [3:0] code);
        llc_khz_t base;
        base = 16'd0;
        case (code[3:2])
            2'd0:    base = 16'd2048;
            2'd1:    base = 16'd1544;
            2'd2:    base = 16'd1536;
            default: base = 16'd32;
        endcase
        return llc_khz_t'(base << code[1:0]);
    endfunction

    // Register select by exact offset match, hi group offsets passed in directly
    function automatic logic hit(input llc_addr_t a, input llc_addr_t lo_ofs);
        return (a == lo_ofs);
    endfunction

    // Register state
    llc_chan_t insert_bits;
    llc_chan_t rx_inv;
    llc_chan_t tx_inv;
    llc_chan_t gate_on_loss;
    llc_chan_t vio_status;
    llc_byte_t clk_cfg;
    llc_byte_t irq_cfg;
    llc_byte_t tester_cfg;
    llc_chan_t insert_tgl;
    llc_byte_t rdata;
    llc_chan_t next_insert_bits;
    llc_chan_t next_rx_inv;
    llc_chan_t next_tx_inv;
    llc_chan_t next_gate_on_loss;
    llc_chan_t next_vio_status;
    llc_byte_t next_clk_cfg;
    llc_byte_t next_irq_cfg;
    llc_byte_t next_tester_cfg;
    llc_chan_t next_insert_tgl;
    llc_byte_t next_rdata;

    // Core-domain synchronisers
    llc_chan_t vt_s1, vt_s2, vt_s3;
    llc_chan_t lv_tgl;
    llc_chan_t los_s1, los_s2, los_s3, los_q;
    llc_chan_t vio_set;
    llc_chan_t rd_clear;
    llc_chan_t wr_clear;
    logic      woc;

    assign woc     = irq_cfg[`LLC_BIT_WOC];
    assign vio_set = vt_s2 ^ vt_s3;

    // Clear masks for status registers
    always_comb begin
        rd_clear = '0;
        wr_clear = '0;
        if (host_rd && !woc && hit(host_addr, `LLC_OFS_STATUS_LO)) begin
            rd_clear[7:0] = 8'hFF;
        end
        if (host_rd && !woc && hit(host_addr, `LLC_OFS_STATUS_HI)) begin
            rd_clear[15:8] = 8'hFF;
        end
        if (host_wr && woc && hit(host_addr, `LLC_OFS_STATUS_LO)) begin
            wr_clear[7:0] = host_wdata;
        end
        if (host_wr && woc && hit(host_addr, `LLC_OFS_STATUS_HI)) begin
            wr_clear[15:8] = host_wdata;
        end
    end

    // Register writes, insert edge detection and read data
    always_comb begin
        next_insert_bits  = insert_bits;
        next_rx_inv       = rx_inv;
        next_tx_inv       = tx_inv;
        next_gate_on_loss = gate_on_loss;
        next_clk_cfg      = clk_cfg;
        next_irq_cfg      = irq_cfg;
        next_tester_cfg   = tester_cfg;
        next_rdata        = rdata;
        // Set wins over clear
        next_vio_status   = (vio_status & ~(rd_clear | wr_clear)) | vio_set;
        if (host_wr) begin
            case (host_addr)
                `LLC_OFS_INSERT_LO: next_insert_bits[7:0]   = host_wdata;
                `LLC_OFS_INSERT_HI: next_insert_bits[15:8]  = host_wdata;
                `LLC_OFS_RX_INV_LO: next_rx_inv[7:0]        = host_wdata;
                `LLC_OFS_RX_INV_HI: next_rx_inv[15:8]       = host_wdata;
                `LLC_OFS_TX_INV_LO: next_tx_inv[7:0]        = host_wdata;
                `LLC_OFS_TX_INV_HI: next_tx_inv[15:8]       = host_wdata;
                `LLC_OFS_GATE_LO:   next_gate_on_loss[7:0]  = host_wdata;
                `LLC_OFS_GATE_HI:   next_gate_on_loss[15:8] = host_wdata;
                `LLC_OFS_CLK_CFG:   next_clk_cfg            = host_wdata;
                `LLC_OFS_IRQ_CFG:   next_irq_cfg = host_wdata & `LLC_IRQ_CFG_MASK;
                `LLC_OFS_TESTER_HI: next_tester_cfg = host_wdata & `LLC_TESTER_MASK;
                default: ;
            endcase
        end
        // Only a 0-to-1 change of a stored bit requests an insert
        next_insert_tgl = insert_tgl ^ (next_insert_bits & ~insert_bits);
        if (host_rd) begin
            case (host_addr)
                `LLC_OFS_INSERT_LO: next_rdata = insert_bits[7:0];
                `LLC_OFS_INSERT_HI: next_rdata = insert_bits[15:8];
                `LLC_OFS_STATUS_LO: next_rdata = vio_status[7:0];
                `LLC_OFS_STATUS_HI: next_rdata = vio_status[15:8];
                `LLC_OFS_RX_INV_LO: next_rdata = rx_inv[7:0];
                `LLC_OFS_RX_INV_HI: next_rdata = rx_inv[15:8];
                `LLC_OFS_TX_INV_LO: next_rdata = tx_inv[7:0];
                `LLC_OFS_TX_INV_HI: next_rdata = tx_inv[15:8];
                `LLC_OFS_GATE_LO:   next_rdata = gate_on_loss[7:0];
                `LLC_OFS_GATE_HI:   next_rdata = gate_on_loss[15:8];
                `LLC_OFS_CLK_CFG:   next_rdata = clk_cfg;
                `LLC_OFS_IRQ_CFG:   next_rdata = irq_cfg;
                `LLC_OFS_TESTER_HI: next_rdata = tester_cfg;
                default:            next_rdata = `LLC_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            insert_bits  <= '0;
            rx_inv       <= '0;
            tx_inv       <= '0;
            gate_on_loss <= '0;
            vio_status   <= '0;
            clk_cfg      <= `LLC_RESET_BYTE;
            irq_cfg      <= `LLC_RESET_BYTE;
            tester_cfg   <= `LLC_RESET_BYTE;
            insert_tgl   <= '0;
            rdata        <= `LLC_RESET_BYTE;
        end else begin
            insert_bits  <= next_insert_bits;
            rx_inv       <= next_rx_inv;
            tx_inv       <= next_tx_inv;
            gate_on_loss <= next_gate_on_loss;
            vio_status   <= next_vio_status;
            clk_cfg      <= next_clk_cfg;
            irq_cfg      <= next_irq_cfg;
            tester_cfg   <= next_tester_cfg;
            insert_tgl   <= next_insert_tgl;
            rdata        <= next_rdata;
        end
    end

    assign host_rdata = rdata;

    // Core synchronisers: violation toggles and loss of signal
    llc_chan_t next_los_q;
    always_comb begin
        next_los_q = los_q;
        for (int i = 0; i < 16; i++) begin
            if (los_s2[i] == los_s3[i]) begin
                next_los_q[i] = los_s3[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vt_s1  <= '0;
            vt_s2  <= '0;
            vt_s3  <= '0;
            los_s1 <= '0;
            los_s2 <= '0;
            los_s3 <= '0;
            los_q  <= '0;
        end else begin
            vt_s1  <= lv_tgl;
            vt_s2  <= vt_s1;
            vt_s3  <= vt_s2;
            los_s1 <= loss_of_signal;
            los_s2 <= los_s1;
            los_s3 <= los_s2;
            los_q  <= next_los_q;
        end
    end

    // Line domain: violation qualify, window, insert pulses, edge select
    llc_chan_t lv_event;
    llc_chan_t lv_accept;
    llc_chan_t next_lv_tgl;
    logic [1:0] lv_win [16];
    logic [1:0] next_lv_win [16];
    llc_chan_t it_s1, it_s2, it_s3;
    llc_chan_t ti_s1, ti_s2, ti_s3;
    llc_chan_t next_tx_insert;
    llc_chan_t next_tx_fall;

    always_comb begin
        lv_event = rx_bpv_event
                 | (rx_zero_run_event & zero_run_detect_enable)
                 | (rx_cv_event & ~code_violation_detect_disable
                    & {16{hdb3_mode}});
        next_lv_tgl = lv_tgl;
        for (int i = 0; i < 16; i++) begin
            lv_accept[i] = lv_event[i] && (lv_win[i] == 2'h0);
            next_lv_win[i] = (lv_win[i] != 2'h0) ? lv_win[i] - 2'h1 : 2'h0;
            if (lv_accept[i]) begin
                next_lv_tgl[i] = ~lv_tgl[i];
                next_lv_win[i] = `LLC_LV_WINDOW;
            end
        end
        next_tx_insert = it_s2 ^ it_s3;
        next_tx_fall   = tx_sample_falling;
        for (int i = 0; i < 16; i++) begin
            if (ti_s2[i] == ti_s3[i]) begin
                next_tx_fall[i] = ti_s3[i];
            end
        end
    end

    always_ff @(posedge line_clk or posedge rst) begin
        if (rst) begin
            lv_tgl              <= '0;
            it_s1               <= '0;
            it_s2               <= '0;
            it_s3               <= '0;
            ti_s1               <= '0;
            ti_s2               <= '0;
            ti_s3               <= '0;
            tx_violation_insert <= '0;
            tx_sample_falling   <= '0;
            for (int i = 0; i < 16; i++) begin
                lv_win[i] <= 2'h0;
            end
        end else begin
            lv_tgl              <= next_lv_tgl;
            it_s1               <= insert_tgl;
            it_s2               <= it_s1;
            it_s3               <= it_s2;
            ti_s1               <= tx_inv;
            ti_s2               <= ti_s1;
            ti_s3               <= ti_s2;
            tx_violation_insert <= next_tx_insert;
            tx_sample_falling   <= next_tx_fall;
            for (int i = 0; i < 16; i++) begin
                lv_win[i] <= next_lv_win[i];
            end
        end
    end

    // Recovered clock outputs: invert, gate low or fall back on loss
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (los_q[i]) begin
                rx_clock_out[i] = gate_on_loss[i] ? 1'b0 : master_clk;
            end else begin
                rx_clock_out[i] = rx_recovered_clk[i] ^ rx_inv[i];
            end
        end
    end

    // PLL reference selection with master clock fallback
    logic [3:0] ref_ch;
    logic       ref_valid;
    always_comb begin
        ref_valid = (pll_ref_bank == `LLC_BANK_LOW) || (pll_ref_bank == `LLC_BANK_HIGH);
        ref_ch    = {pll_ref_bank == `LLC_BANK_HIGH, clk_cfg[7:5]};
        if (ref_valid && !los_q[ref_ch]) begin
            pll_ref_clk = rx_recovered_clk[ref_ch];
        end else begin
            pll_ref_clk = master_clk;
        end
    end

    // Global clock outputs and tester channel select
    logic [7:0] next_tester_onehot;
    always_comb begin
        next_tester_onehot = 8'h00;
        if (tester_cfg[`LLC_BIT_TESTER_EN]) begin
            next_tester_onehot = 8'(8'h01 << tester_cfg[7:5]);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pll_ref_channel       <= 4'h0;
            rate_clock_2048       <= 1'b0;
            aux_clock_khz         <= 16'h0800;
            tester_channel_onehot <= 8'h00;
        end else begin
            pll_ref_channel       <= ref_ch;
            rate_clock_2048       <= clk_cfg[`LLC_BIT_RATE];
            aux_clock_khz         <= aux_khz(clk_cfg[3:0]);
            tester_channel_onehot <= next_tester_onehot;
        end
    end

    // Interrupt pin drive
    always_comb begin
        irq_n_o  = !irq_active;
        irq_n_oe = irq_active || irq_cfg[`LLC_BIT_IDLE_DRIVE];
    end

    // Checks
    property p_insert_pulse;
        @(posedge line_clk) disable iff (rst)
        (it_s2 ^ it_s3) != '0 |=> tx_violation_insert == $past(it_s2 ^ it_s3);
    endproperty
    a_insert_pulse: assert property (p_insert_pulse)
        else $error("insert pulse missing");

    property p_insert_edge;
        @(posedge core_clk) disable iff (rst)
        host_wr && host_addr == `LLC_OFS_INSERT_LO && (host_wdata & ~insert_bits[7:0]) != 8'h00
        |=> insert_tgl[7:0] != $past(insert_tgl[7:0]);
    endproperty
    a_insert_edge: assert property (p_insert_edge)
        else $error("insert edge not detected");

    property p_insert_hold;
        @(posedge core_clk) disable iff (rst)
        host_wr && host_addr == `LLC_OFS_INSERT_LO && host_wdata == insert_bits[7:0]
        |=> insert_tgl[7:0] == $past(insert_tgl[7:0]);
    endproperty
    a_insert_hold: assert property (p_insert_hold)
        else $error("held insert bit requested again");

    property p_status_set;
        @(posedge core_clk) disable iff (rst)
        vio_set[0] |=> vio_status[0];
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("violation not latched");

    property p_read_clear;
        @(posedge core_clk) disable iff (rst)
        host_rd && !woc && host_addr == `LLC_OFS_STATUS_LO && vio_set[7:0] == 8'h00
        |=> vio_status[7:0] == 8'h00 && host_rdata == $past(vio_status[7:0]);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status not cleared by read");

    property p_woc_read_keeps;
        @(posedge core_clk) disable iff (rst)
        host_rd && !host_wr && woc |=> (vio_status & $past(vio_status)) == $past(vio_status);
    endproperty
    a_woc_read_keeps: assert property (p_woc_read_keeps)
        else $error("read cleared status in write-one mode");

    property p_window;
        @(posedge line_clk) disable iff (rst)
        lv_accept[0] |=> !lv_accept[0] [*3] ##1 (lv_event[0] -> lv_accept[0]);
    endproperty
    a_window: assert property (p_window)
        else $error("violation window wrong");

    property p_zero_gate;
        @(posedge line_clk) disable iff (rst)
        !zero_run_detect_enable[0] && !rx_bpv_event[0] && !rx_cv_event[0] |-> !lv_accept[0];
    endproperty
    a_zero_gate: assert property (p_zero_gate)
        else $error("zero run counted while disabled");

    property p_cv_gate;
        @(posedge line_clk) disable iff (rst)
        (!hdb3_mode || code_violation_detect_disable[0]) && !rx_bpv_event[0]
        && !rx_zero_run_event[0] |-> !lv_accept[0];
    endproperty
    a_cv_gate: assert property (p_cv_gate)
        else $error("code violation counted when excluded");

    property p_tester_off;
        @(posedge core_clk) disable iff (rst)
        !tester_cfg[`LLC_BIT_TESTER_EN] |=> tester_channel_onehot == 8'h00;
    endproperty
    a_tester_off: assert property (p_tester_off)
        else $error("tester selected while disabled");

    property p_irq_pin;
        @(posedge core_clk) disable iff (rst)
        irq_active |-> !irq_n_o && irq_n_oe;
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt pin not driven low");

    property p_gate_low;
        @(posedge core_clk) disable iff (rst)
        los_q[0] && gate_on_loss[0] |-> !rx_clock_out[0];
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("gated clock not low");
endmodule

// ==== tb/llc_framer_model.sv ====
`timescale 1ns/1ps
// Framer side of the line: recovered clocks and violation pulses
module llc_framer_model (
    input  wire logic               line_clk,
    input  wire logic               rst,
    input  wire llc_pkg::llc_chan_t tx_sample_falling,
    output llc_pkg::llc_chan_t      rx_bpv_event,
    output llc_pkg::llc_chan_t      rx_cv_event,
    output llc_pkg::llc_chan_t      rx_zero_run_event,
    output llc_pkg::llc_chan_t      rx_recovered_clk
);
    import llc_pkg::*;
    llc_chan_t tx_launch_falling;
    // Transmit rail data launched on the edge the device samples
    assign tx_launch_falling = tx_sample_falling;
    // Free running recovered clocks in two phases
    always_ff @(posedge line_clk or posedge rst) begin
        if (rst) begin
            rx_recovered_clk <= 16'h00FF;
        end else begin
            rx_recovered_clk <= ~rx_recovered_clk;
        end
    end
    // Quiet receive side at time zero
    initial begin
        rx_bpv_event = 16'h0000;
        rx_cv_event = 16'h0000;
        rx_zero_run_event = 16'h0000;
    end
    // One link cycle pulse, again gap cycles later when gap is set
    task automatic send(input logic [1:0] kind, input llc_chan_t mask, input int gap);
        llc_chan_t p;
        for (int i = 0; i <= gap + 1; i++) begin
            @(posedge line_clk);
            p = (i == 0 || i == gap) ? mask : 16'h0000;
            rx_bpv_event <= (kind == 2'h0) ? p : 16'h0000;
            rx_cv_event <= (kind == 2'h1) ? p : 16'h0000;
            rx_zero_run_event <= (kind == 2'h2) ? p : 16'h0000;
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// Bench for the line clock control registers
module tb_top;
    import llc_pkg::*;
    logic       core_clk, line_clk, master_clk, rst, host_wr, host_rd, hdb3_mode;
    logic       irq_active, pll_ref_clk, rate_clock_2048, irq_n_o, irq_n_oe;
    logic [1:0] pll_ref_bank;
    logic [3:0] pll_ref_channel;
    logic [7:0] tester_channel_onehot;
    llc_addr_t  host_addr;
    llc_byte_t  host_wdata, host_rdata, rd_val;
    llc_khz_t   aux_clock_khz;
    llc_chan_t  rx_bpv_event, rx_cv_event, rx_zero_run_event, rx_recovered_clk;
    llc_chan_t  zero_run_detect_enable, code_violation_detect_disable, loss_of_signal;
    llc_chan_t  tx_violation_insert, tx_sample_falling, rx_clock_out, ins_seen;
    int         failures, checks_done, ins_cnt;
    llc_khz_t   aux_khz [16] = '{16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h0608,
        16'h0C10, 16'h1820, 16'h3040, 16'h0600, 16'h0C00, 16'h1800, 16'h3000,
        16'h0020, 16'h0040, 16'h0080, 16'h0100};
    llc_line_clock_regs i_dut (
        .core_clk, .rst, .line_clk, .host_addr, .host_wdata, .host_wr, .host_rd,
        .host_rdata, .rx_bpv_event, .rx_cv_event, .rx_zero_run_event,
        .zero_run_detect_enable, .code_violation_detect_disable, .hdb3_mode,
        .tx_violation_insert, .tx_sample_falling, .rx_recovered_clk, .loss_of_signal,
        .master_clk, .rx_clock_out, .pll_ref_bank, .pll_ref_clk, .pll_ref_channel,
        .rate_clock_2048, .aux_clock_khz, .irq_active, .irq_n_o, .irq_n_oe,
        .tester_channel_onehot);
    llc_framer_model i_framer (.line_clk, .rst, .tx_sample_falling, .rx_bpv_event,
        .rx_cv_event, .rx_zero_run_event, .rx_recovered_clk);
    // Core, link and master clocks, master at 2.048 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        line_clk = 1'b0;
        #3;
        forever #24 line_clk = ~line_clk;
    end
    initial begin
        master_clk = 1'b0;
        forever #244.141 master_clk = ~master_clk;
    end
    // Counts transmit violation pulses, one per channel bit
    always @(posedge line_clk) begin
        if (tx_violation_insert !== 16'h0000) begin
            ins_cnt += $countones(tx_violation_insert);
            ins_seen |= tx_violation_insert;
        end
    end
    // Compare helpers
    task automatic chk_val(input llc_khz_t g, input llc_khz_t e, input string m);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        chk_val({15'h0000, g}, {15'h0000, e}, m);
    endtask
    // Closing report
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Host register cycles and waits
    task automatic wr(input llc_addr_t a, input llc_byte_t d);
        @(posedge core_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge core_clk);
        host_wr <= 1'b0;
    endtask
    task automatic rd(input llc_addr_t a);
        @(posedge core_clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge core_clk);
        host_rd <= 1'b0;
        #1;
        rd_val = host_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Reset values, unmapped place included
    task automatic t_reset();
        llc_addr_t ofs [14] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h1E,
            6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h36, 6'h3F};
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk_val(rd_val, 16'h0000, "reset value");
        end
        chk_val(aux_clock_khz, 16'h0800, "aux reset");
        $display("reset test done");
    endtask
    // Insert requests on edges only, held bit inserts nothing
    task automatic t_insert();
        ins_cnt = 0;
        ins_seen = 16'h0000;
        wr(6'h11, 8'h01);
        wr(6'h31, 8'h80);
        cyc(40);
        wr(6'h11, 8'h01);
        wr(6'h31, 8'h80);
        cyc(40);
        chk_val(llc_khz_t'(ins_cnt), 16'h0002, "held bit");
        wr(6'h11, 8'h00);
        wr(6'h11, 8'h01);
        cyc(40);
        chk_val(llc_khz_t'(ins_cnt), 16'h0003, "rearmed insert");
        chk_val(ins_seen, 16'h8001, "insert channel");
        $display("insert test done");
    endtask
    // One violation, then read twice
    task automatic lv(input logic [1:0] k, input llc_chan_t m, input llc_addr_t a,
                      input llc_byte_t e);
        i_framer.send(k, m, 0);
        cyc(12);
        rd(a);
        chk_val(rd_val, e, "status");
        rd(a);
        chk_val(rd_val, 16'h0000, "cleared by read");
    endtask
    // Violation kinds and their enables
    task automatic t_status();
        lv(2'h0, 16'h0001, 6'h12, 8'h01);
        lv(2'h0, 16'h8000, 6'h32, 8'h80);
        lv(2'h2, 16'h0002, 6'h12, 8'h00);
        zero_run_detect_enable <= 16'h0002;
        lv(2'h2, 16'h0002, 6'h12, 8'h02);
        lv(2'h1, 16'h0004, 6'h12, 8'h00);
        hdb3_mode <= 1'b1;
        lv(2'h1, 16'h0004, 6'h12, 8'h04);
        code_violation_detect_disable <= 16'h0004;
        lv(2'h1, 16'h0004, 6'h12, 8'h00);
        $display("status test done");
    endtask
    // Two violations gap link cycles apart, status read between them
    task automatic t_window(input int gap, input llc_byte_t e2);
        int i;
        fork
            i_framer.send(2'h0, 16'h0001, gap);
        join_none
        for (i = 0; i < 100 && rx_bpv_event[0] !== 1'b1; i++) @(posedge core_clk);
        if (i == 100) begin
            failures++;
            finish_test();
        end
        cyc(10);
        rd(6'h12);
        chk_val(rd_val, 16'h0001, "first violation");
        cyc(40);
        rd(6'h12);
        chk_val(rd_val, e2, "second violation");
        $display("window test done");
    endtask
    // Clear by writing ones, then interrupt pin drive
    task automatic t_woc_irq();
        wr(6'h1E, 8'h01);
        i_framer.send(2'h0, 16'h0010, 0);
        cyc(12);
        rd(6'h12);
        rd(6'h12);
        chk_val(rd_val, 16'h0010, "read keeps bit");
        wr(6'h12, 8'h01);
        rd(6'h12);
        chk_val(rd_val, 16'h0010, "other bit written");
        wr(6'h12, 8'h10);
        rd(6'h12);
        chk_val(rd_val, 16'h0000, "write one clears");
        wr(6'h1E, 8'hFE);
        rd(6'h1E);
        chk_val(rd_val, 16'h0002, "irq config");
        chk_bit(irq_n_oe & irq_n_o, 1'b1, "idle drives high");
        irq_active <= 1'b1;
        wr(6'h1E, 8'h00);
        cyc(2);
        chk_bit(irq_n_oe & ~irq_n_o, 1'b1, "active drives low");
        irq_active <= 1'b0;
        cyc(2);
        chk_bit(irq_n_oe, 1'b0, "idle floats");
        $display("irq test done");
    endtask
    // Rate bit, aux codes, reference selection and fallback
    task automatic t_clocks();
        for (int k = 0; k < 16; k++) begin
            wr(6'h15, {3'h0, k[0], k[3:0]});
            cyc(2);
            chk_val(aux_clock_khz, aux_khz[k], "aux frequency");
            chk_bit(rate_clock_2048, k[0], "rate clock");
        end
        for (int b = 1; b < 3; b++) begin
            for (int k = 0; k < 8; k++) begin
                pll_ref_bank <= b[1:0];
                wr(6'h15, {k[2:0], 5'h00});
                cyc(3);
                chk_val(16'(pll_ref_channel), 16'(k + 8 * b - 8), "ref");
            end
        end
        chk_bit(pll_ref_clk, rx_recovered_clk[15], "ref clock");
        loss_of_signal <= 16'h8000;
        cyc(8);
        chk_bit(pll_ref_clk, master_clk, "ref on loss");
        loss_of_signal <= 16'h0000;
        cyc(8);
        chk_bit(pll_ref_clk, rx_recovered_clk[15], "ref restored");
        pll_ref_bank <= 2'h3;
        cyc(2);
        chk_bit(pll_ref_clk, master_clk, "bank unset");
        $display("clock test done");
    endtask
    // Receive clock polarity, loss handling, transmit polarity, tester
    task automatic t_paths();
        wr(6'h13, 8'h01);
        cyc(2);
        chk_bit(rx_clock_out[0], ~rx_recovered_clk[0], "rx invert");
        loss_of_signal <= 16'h0001;
        cyc(8);
        chk_bit(rx_clock_out[0], master_clk, "master on loss");
        wr(6'h16, 8'h01);
        cyc(2);
        chk_bit(rx_clock_out[0], 1'b0, "gated low");
        wr(6'h14, 8'h01);
        wr(6'h34, 8'h80);
        cyc(30);
        chk_val(tx_sample_falling, 16'h8001, "tx invert");
        for (int k = 0; k < 8; k++) begin
            wr(6'h30, {k[2:0], 5'h01});
            cyc(2);
            chk_val(tester_channel_onehot, 16'h0001 << k, "tester");
        end
        wr(6'h30, 8'hFE);
        rd(6'h30);
        chk_val(rd_val, 16'h00E0, "tester readback");
        chk_val(tester_channel_onehot, 16'h0000, "tester off");
        $display("path test done");
    endtask
    // Main sequence
    initial begin
        {rst, host_wr, host_rd, hdb3_mode, irq_active} = 5'h10;
        {host_addr, host_wdata, pll_ref_bank} = 16'h0000;
        {zero_run_detect_enable, code_violation_detect_disable} = 32'h0000_0000;
        loss_of_signal = 16'h0000;
        {failures, checks_done, ins_cnt} = 96'h0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_insert();
        t_status();
        t_window(3, 8'h00);
        t_window(4, 8'h01);
        t_woc_irq();
        t_clocks();
        t_paths();
        finish_test();
    end
endmodule
